/* rtl/tpcr_pkg.sv */
// Purpose: shared constants for the port role and init control block
// Assumes: clk_sys at 125 MHz, registers reached over AXI4-Lite
// Notes: tick-based timing, counts derived from the clock period
// How it works
// R01: strapped address pin selects management mode
// R02: strap tied low gives address 0x47
// R03: register change drives open-drain change alert
// R04: orientation output steers external lane mux
// R05: flag names CC line, inverted when swapped
// R06: role select 2'b01 means upstream port
// R07: role change, soft reset, enable fall exit
// R08: unpowered default presents Rd on both lines
// R09: reset enters unattached sink, dual role
// R10: host writes role select if not dual
// R11: downstream watches CC, upstream watches VBUS
// R12: active mode only after detected attach
// R13: role select 2'b10 means downstream port
package tpcr_pkg;
   // timing: one microsecond enable tick
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned TICK_US       = 1;
   localparam int unsigned TICK_CYCLES   = (TICK_US * 1000000) / CLK_PERIOD_PS;
   localparam int unsigned TOGGLE_US     = 50000;
   localparam int unsigned DEBOUNCE_US   = 200;
   localparam int unsigned TOGGLE_TICKS  = TOGGLE_US / TICK_US;
   localparam int unsigned DEBOUNCE_TICKS = DEBOUNCE_US / TICK_US;
   // register byte offsets
   localparam int unsigned AXI_ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_INT_STAT = 8'h08;
   localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
   localparam logic [7:0] ADDR_ID       = 8'h10;
   localparam logic [31:0] ID_VALUE     = 32'h0000_5A01; // arbitrary value
   // control fields
   localparam int unsigned CTRL_SOFT_RST = 2;
   localparam int unsigned CTRL_CC_SWAP  = 3;
   localparam logic [1:0]  ROLE_DRP      = 2'h0;
   localparam logic [1:0]  ROLE_UFP      = 2'h1;
   localparam logic [1:0]  ROLE_DFP      = 2'h2;
   // address strap codes and targets
   localparam logic [1:0] STRAP_LOW      = 2'h1;
   localparam logic [1:0] STRAP_HIGH     = 2'h2;
   localparam logic [6:0] MGMT_ADDR_LOW  = 7'h47;
   localparam logic [6:0] MGMT_ADDR_HIGH = 7'h40;
   // interrupt bits
   localparam int unsigned INT_W         = 3;
   localparam int unsigned INT_ATTACH    = 0;
   localparam int unsigned INT_DETACH    = 1;
   localparam int unsigned INT_ROLE_EXIT = 2;
   localparam logic [INT_W-1:0] MASK_RESET = 3'h0;
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {ST_UNATT_SNK, ST_UNATT_SRC, ST_ATT_SNK, ST_ATT_SRC} tpcr_state_t;
endpackage

/* rtl/tpcr_reg_if.sv */
// Purpose: register access strobes between bus front end and core
// Assumes: single clock, one access of each kind at a time
// Notes: errors and read data are combinational from the core
`timescale 1ns/100ps
interface tpcr_reg_if;
   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_err;
   logic        rd_en;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        rd_err;
   modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  input wr_err, rd_data, rd_err);
   modport regs  (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface // tpcr_reg_if

/* rtl/tpcr_axil_slave.sv */
// Purpose: AXI4-Lite slave front end for the role control registers
// Assumes: one write and one read under way at a time
// Notes: address and data are taken in either order
`timescale 1ns/100ps
module tpcr_axil_slave
   import tpcr_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rstn,
   input  wire logic [AXI_ADDR_W-1:0] s_awaddr,
   input  wire logic                  s_awvalid,
   output wire logic                  s_awready,
   input  wire logic [31:0]           s_wdata,
   input  wire logic [3:0]            s_wstrb,
   input  wire logic                  s_wvalid,
   output wire logic                  s_wready,
   output      logic [1:0]            s_bresp,
   output      logic                  s_bvalid,
   input  wire logic                  s_bready,
   input  wire logic [AXI_ADDR_W-1:0] s_araddr,
   input  wire logic                  s_arvalid,
   output wire logic                  s_arready,
   output      logic [31:0]           s_rdata,
   output      logic [1:0]            s_rresp,
   output      logic                  s_rvalid,
   input  wire logic                  s_rready,
   tpcr_reg_if.slave                  regs
);
   logic aw_held;
   logic w_held;

   // a held half blocks its channel until the response goes out
   assign s_awready = !aw_held && !s_bvalid;
   assign s_wready  = !w_held && !s_bvalid;
   assign regs.wr_en = aw_held && w_held && !s_bvalid;

   // write address capture
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         aw_held <= 1'b0;
         regs.wr_addr <= 8'h00;
      end else if (s_awvalid && s_awready) begin
         aw_held <= 1'b1;
         regs.wr_addr <= s_awaddr;
      end else if (regs.wr_en) begin
         aw_held <= 1'b0;
      end
   end

   // write data capture
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         w_held <= 1'b0;
         regs.wr_data <= 32'h0000_0000;
         regs.wr_strb <= 4'h0;
      end else if (s_wvalid && s_wready) begin
         w_held <= 1'b1;
         regs.wr_data <= s_wdata;
         regs.wr_strb <= s_wstrb;
      end else if (regs.wr_en) begin
         w_held <= 1'b0;
      end
   end

   // write response
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_bvalid <= 1'b0;
         s_bresp <= RESP_OKAY;
      end else if (regs.wr_en) begin
         s_bvalid <= 1'b1;
         s_bresp <= regs.wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   // read: data sampled in the cycle the address is taken
   assign s_arready = !s_rvalid;
   assign regs.rd_en = s_arvalid && s_arready;
   assign regs.rd_addr = s_araddr;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= RESP_OKAY;
      end else if (regs.rd_en) begin
         s_rvalid <= 1'b1;
         s_rdata <= regs.rd_data;
         s_rresp <= regs.rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_rready) begin
         s_rvalid <= 1'b0;
      end
   end
endmodule // tpcr_axil_slave

/* rtl/tpcr_ctrl.sv */
// Purpose: Type-C port role selection, attach tracking and power-up
// Assumes: CC and VBUS comparators are analog; their flags are synchronous
// Notes: all timing runs off a one microsecond enable tick
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
module tpcr_ctrl
   import tpcr_pkg::*;
#(
   parameter int unsigned TOGGLE_T   = TOGGLE_TICKS,
   parameter int unsigned DEBOUNCE_T = DEBOUNCE_TICKS
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rstn,
   // register bus
   input  wire logic [AXI_ADDR_W-1:0] s_awaddr,
   input  wire logic                  s_awvalid,
   output wire logic                  s_awready,
   input  wire logic [31:0]           s_wdata,
   input  wire logic [3:0]            s_wstrb,
   input  wire logic                  s_wvalid,
   output wire logic                  s_wready,
   output wire logic [1:0]            s_bresp,
   output wire logic                  s_bvalid,
   input  wire logic                  s_bready,
   input  wire logic [AXI_ADDR_W-1:0] s_araddr,
   input  wire logic                  s_arvalid,
   output wire logic                  s_arready,
   output wire logic [31:0]           s_rdata,
   output wire logic [1:0]            s_rresp,
   output wire logic                  s_rvalid,
   input  wire logic                  s_rready,
   // straps and pins
   input  wire logic [1:0]            addr_strap,
   input  wire logic                  en_n,
   input  wire logic                  vbus_sense_pin,
   input  wire logic                  cc1_rp_det,
   input  wire logic                  cc2_rp_det,
   input  wire logic                  cc1_rd_det,
   input  wire logic                  cc2_rd_det,
   input  wire logic                  change_alert_in,
   output wire logic                  change_alert_out,
   output wire logic                  change_alert_oe,
   output      logic                  mgmt_mode,
   output      logic [6:0]            mgmt_addr,
   output      logic                  cc_rp_en,
   output      logic                  cc_rd_en,
   output      logic                  orientation_out,
   output      logic                  active_mode,
   output      logic                  irq
);
   localparam int unsigned DIV_W = $clog2(TICK_CYCLES);
   localparam int unsigned TOG_W = $clog2(TOGGLE_T + 1);
   localparam int unsigned DEB_W = $clog2(DEBOUNCE_T + 1);

   if (TICK_CYCLES < 2) begin : g_chk_tick
      $error("tick divider needs at least two cycles");
   end
   if (TOGGLE_T < 1 || DEBOUNCE_T < 1) begin : g_chk_time
      $error("toggle and debounce times must be at least one tick");
   end

   tpcr_reg_if bus ();

   tpcr_axil_slave u_slave (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .regs      (bus.slave)
   );

   tpcr_state_t      state;
   tpcr_state_t      next_state;
   tpcr_state_t      role_home;
   logic [DIV_W-1:0] div_cnt;
   logic             tick;
   logic             strap_taken;
   logic             en_n_q;
   logic             en_fall;
   logic [1:0]       role;
   logic             cc_swap;
   logic             ctrl_wr;
   logic             role_chg;
   logic             soft_rst;
   logic             restart;
   logic             role_drp;
   logic [TOG_W-1:0] tog_cnt;
   logic             tog_done;
   logic [DEB_W-1:0] deb_cnt;
   logic             cand;
   logic             attach_ok;
   logic             cc_sel;
   logic             line_rd;
   logic             attached;
   logic             attaching;
   logic             detaching;
   logic [INT_W-1:0] int_stat;
   logic [INT_W-1:0] int_mask;
   logic [INT_W-1:0] int_ev;
   logic [INT_W-1:0] int_clr;

   // one microsecond enable from the system clock
   assign tick = (div_cnt == DIV_W'(TICK_CYCLES - 1));

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         div_cnt <= '0;
      end else if (tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + DIV_W'(1);
      end
   end

   // R01: strap picks management mode
   // R02: low strap gives address 0x47
   // the strap is caught once after reset release, never under reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         strap_taken <= 1'b0;
         mgmt_mode <= 1'b0;
         mgmt_addr <= MGMT_ADDR_LOW;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         mgmt_mode <= (addr_strap == STRAP_LOW) || (addr_strap == STRAP_HIGH);
         mgmt_addr <= (addr_strap == STRAP_HIGH) ? MGMT_ADDR_HIGH : MGMT_ADDR_LOW;
      end
   end

   // enable pin history; reset low so a pin held low is no false edge
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         en_n_q <= 1'b0;
      end else begin
         en_n_q <= en_n;
      end
   end

   assign en_fall = en_n_q && !en_n;

   // control register write decode
   assign ctrl_wr  = bus.wr_en && (bus.wr_addr == ADDR_CTRL) && bus.wr_strb[0];
   assign role_chg = ctrl_wr && (bus.wr_data[1:0] != role);
   assign soft_rst = ctrl_wr && bus.wr_data[CTRL_SOFT_RST];

   // R07: leave role on change, reset, enable fall
   assign restart = role_chg || soft_rst || en_fall;

   // R09: role resets to dual; host may change it
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         role <= ROLE_DRP;
         cc_swap <= 1'b0;
      end else if (ctrl_wr) begin
         role <= bus.wr_data[1:0];
         cc_swap <= bus.wr_data[CTRL_CC_SWAP];
      end
   end

   // R06: 2'b01 parks as upstream port
   // R13: 2'b10 parks as downstream port
   // the reserved code 2'b11 behaves as dual role
   assign role_drp  = (role != ROLE_UFP) && (role != ROLE_DFP);
   assign role_home = (role == ROLE_DFP) ? ST_UNATT_SRC : ST_UNATT_SNK;

   // R11: sink watches VBUS, source watches CC
   always_comb begin
      unique case (state)
         ST_UNATT_SNK: cand = vbus_sense_pin && (cc1_rp_det || cc2_rp_det);
         ST_UNATT_SRC: cand = cc1_rd_det || cc2_rd_det;
         ST_ATT_SNK:   cand = 1'b0;
         ST_ATT_SRC:   cand = 1'b0;
      endcase
   end

   // attach must hold for the whole debounce time before it counts
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         deb_cnt <= '0;
      end else if (!cand || en_n || restart || next_state != state) begin
         deb_cnt <= '0;
      end else if (tick && deb_cnt != DEB_W'(DEBOUNCE_T)) begin
         deb_cnt <= deb_cnt + DEB_W'(1);
      end
   end

   assign attach_ok = cand && (deb_cnt == DEB_W'(DEBOUNCE_T));

   // dual-role toggle timer, held at zero while an attach is being qualified
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         tog_cnt <= '0;
      end else if (cand || en_n || restart || next_state != state) begin
         tog_cnt <= '0;
      end else if (tick) begin
         tog_cnt <= tog_cnt + TOG_W'(1);
      end
   end

   assign tog_done = tick && (tog_cnt == TOG_W'(TOGGLE_T - 1));

   // partner Rd still seen on the line caught at attach
   assign line_rd = cc_sel ? cc2_rd_det : cc1_rd_det;

   // R12: active only after qualified attach
   always_comb begin
      next_state = state;
      if (en_n) begin
         next_state = ST_UNATT_SNK;
      end else if (restart) begin
         next_state = role_home;
      end else begin
         unique case (state)
            ST_UNATT_SNK: begin
               if (attach_ok) begin
                  next_state = ST_ATT_SNK;
               end else if (role == ROLE_DFP || (role_drp && tog_done)) begin
                  next_state = ST_UNATT_SRC;
               end
            end
            ST_UNATT_SRC: begin
               if (attach_ok) begin
                  next_state = ST_ATT_SRC;
               end else if (role == ROLE_UFP || (role_drp && tog_done)) begin
                  next_state = ST_UNATT_SNK;
               end
            end
            ST_ATT_SNK: begin
               if (!vbus_sense_pin) begin
                  next_state = role_home;
               end
            end
            ST_ATT_SRC: begin
               if (!line_rd) begin
                  next_state = role_home;
               end
            end
         endcase
      end
   end

   // R09: reset lands in unattached sink
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= ST_UNATT_SNK;
      end else begin
         state <= next_state;
      end
   end

   // R08: Rd on both lines by default
   // pulls follow the next state so they change with the state itself
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cc_rp_en <= 1'b0;
         cc_rd_en <= 1'b1;
         active_mode <= 1'b0;
      end else begin
         cc_rp_en <= (next_state == ST_UNATT_SRC) || (next_state == ST_ATT_SRC);
         cc_rd_en <= (next_state == ST_UNATT_SNK) || (next_state == ST_ATT_SNK);
         active_mode <= (next_state == ST_ATT_SNK) || (next_state == ST_ATT_SRC);
      end
   end

   assign attached  = (state == ST_ATT_SNK) || (state == ST_ATT_SRC);
   assign attaching = !attached && attach_ok && !en_n && !restart;
   assign detaching = attached && (next_state != state);

   // remember which CC line carries the connection, CC1 wins a tie
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cc_sel <= 1'b0;
      end else if (attaching && state == ST_UNATT_SNK) begin
         cc_sel <= !cc1_rp_det;
      end else if (attaching) begin
         cc_sel <= !cc1_rd_det;
      end
   end

   // R05: flag inverts when board swaps lines
   // R04: orientation output steers lane mux
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         orientation_out <= 1'b0;
      end else begin
         orientation_out <= cc_sel ^ cc_swap;
      end
   end

   // interrupt events, set wins over a same-cycle clear
   assign int_ev[INT_ATTACH]    = attaching;
   assign int_ev[INT_DETACH]    = detaching;
   assign int_ev[INT_ROLE_EXIT] = restart;
   assign int_clr = (bus.wr_en && bus.wr_addr == ADDR_INT_STAT && bus.wr_strb[0])
                    ? bus.wr_data[INT_W-1:0] : '0;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         int_stat <= '0;
      end else begin
         int_stat <= (int_stat & ~int_clr) | int_ev;
      end
   end

   // interrupt enables, one per status bit
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         int_mask <= MASK_RESET;
      end else if (bus.wr_en && bus.wr_addr == ADDR_INT_MASK && bus.wr_strb[0]) begin
         int_mask <= bus.wr_data[INT_W-1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((((int_stat & ~int_clr) | int_ev)) & int_mask);
      end
   end

   // R03: open-drain alert pulls low on change
   // only ever driven low; the board pull-up supplies the high level
   assign change_alert_out = 1'b0;
   assign change_alert_oe  = irq;

   // register read mux; unmapped offsets answer with an error
   always_comb begin
      bus.rd_err = 1'b0;
      unique case (bus.rd_addr)
         ADDR_CTRL:     bus.rd_data = {28'h0000000, cc_swap, 1'b0, role};
         ADDR_STATUS:   bus.rd_data = {17'h0000, mgmt_addr, 1'b0,
                                       change_alert_in, mgmt_mode, vbus_sense_pin,
                                       state, orientation_out, active_mode};
         ADDR_INT_STAT: bus.rd_data = {29'h0000000, int_stat};
         ADDR_INT_MASK: bus.rd_data = {29'h0000000, int_mask};
         ADDR_ID:       bus.rd_data = ID_VALUE;
         default: begin
            bus.rd_data = 32'h0000_0000;
            bus.rd_err = 1'b1;
         end
      endcase
   end

   // writes to read-only words are ignored without error
   assign bus.wr_err = !((bus.wr_addr == ADDR_CTRL) || (bus.wr_addr == ADDR_STATUS) ||
                         (bus.wr_addr == ADDR_INT_STAT) || (bus.wr_addr == ADDR_INT_MASK) ||
                         (bus.wr_addr == ADDR_ID));
endmodule // tpcr_ctrl

/* verification/tpcr_partner.sv */
// Purpose: far-side cable partner model for the role control block
// Assumes: comparator flags are plain levels, no pull on them
// Notes: kind 0 none, 1 source partner, 2 sink partner
`timescale 1ns/100ps
module tpcr_partner (
   input  wire logic [1:0] kind,
   input  wire logic       flip,
   input  wire logic       cc_rp_en,
   input  wire logic       cc_rd_en,
   output      logic       vbus_sense_pin,
   output      logic       cc1_rp_det,
   output      logic       cc2_rp_det,
   output      logic       cc1_rd_det,
   output      logic       cc2_rd_det
);
   // attach cues
   // a partner resistor only shows where our opposite pull sits
   always_comb begin
      vbus_sense_pin = (kind == 2'h1);
      cc1_rp_det     = (kind == 2'h1) && cc_rd_en && !flip;
      cc2_rp_det     = (kind == 2'h1) && cc_rd_en && flip;
      cc1_rd_det     = (kind == 2'h2) && cc_rp_en && !flip;
      cc2_rd_det     = (kind == 2'h2) && cc_rp_en && flip;
   end
endmodule // tpcr_partner

/* verification/tpcr_ctrl_assertions.sv */
// Purpose: concurrent checks on the port role control top
// Assumes: strap changes only while reset is low
// Notes: bound to tpcr_ctrl below
`timescale 1ns/100ps
module tpcr_ctrl_assertions
   import tpcr_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rstn,
   input wire logic [1:0] addr_strap,
   input wire logic       en_n,
   input wire logic       vbus_sense_pin,
   input wire logic       cc1_rp_det,
   input wire logic       cc2_rp_det,
   input wire logic       cc1_rd_det,
   input wire logic       cc2_rd_det,
   input wire logic       change_alert_out,
   input wire logic       change_alert_oe,
   input wire logic       mgmt_mode,
   input wire logic [6:0] mgmt_addr,
   input wire logic       cc_rp_en,
   input wire logic       cc_rd_en,
   input wire logic       active_mode,
   input wire logic       irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // attach cues of both unattached states ORed, whatever the state
   wire logic cand = (vbus_sense_pin && (cc1_rp_det || cc2_rp_det)) || cc1_rd_det || cc2_rd_det;
   sequence s_home; cc_rd_en && !cc_rp_en && !active_mode; endsequence
   sequence s_sink_lost; active_mode && cc_rd_en && !vbus_sense_pin; endsequence
   sequence s_src_lost; active_mode && cc_rp_en && !cc1_rd_det && !cc2_rd_det; endsequence
   property p_strap_mode;
      $past(rstn) |-> mgmt_mode == (addr_strap == STRAP_LOW || addr_strap == STRAP_HIGH);
   endproperty
   property p_strap_addr;
      $past(rstn) && addr_strap == STRAP_LOW |-> mgmt_addr == MGMT_ADDR_LOW;
   endproperty
   property p_alert; change_alert_oe == irq && !change_alert_out; endproperty
   property p_home; $rose(rstn) |-> s_home; endproperty
   property p_act_cause;
      $rose(active_mode) |-> $past(cand) && $past(cand, 8) && !$past(en_n);
   endproperty
   property p_sink_leave; s_sink_lost |=> !active_mode; endproperty
   property p_src_leave; s_src_lost |=> !active_mode; endproperty
   property p_park; en_n |-> ##[1:2] s_home; endproperty
   a_strap_mode: assert property (p_strap_mode) else $error("mode vs strap");
   a_strap_addr: assert property (p_strap_addr) else $error("address vs strap");
   a_alert: assert property (p_alert) else $error("alert pin vs irq");
   a_home: assert property (p_home) else $error("not sink after reset");
   a_act_cause: assert property (p_act_cause) else $error("active without attach");
   a_sink_leave: assert property (p_sink_leave) else $error("sink kept w/o vbus");
   a_src_leave: assert property (p_src_leave) else $error("source kept w/o Rd");
   a_park: assert property (p_park) else $error("not parked while disabled");
endmodule // tpcr_ctrl_assertions

bind tpcr_ctrl tpcr_ctrl_assertions chk_u (.*);

/* verification/tb_top.sv */
// Purpose: self-checking bench for the port role control block
// Assumes: toggle 20 ticks, debounce 3 ticks for a short run
// Notes: register reads in a table, role flows written out by hand
`timescale 1ns/100ps
module tb_top
   import tpcr_pkg::*;
;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [1:0]  r;
   } tpcr_row_t;
   tpcr_row_t   rows [5] = '{'{ADDR_ID, ID_VALUE, RESP_OKAY},
      '{ADDR_STATUS, 32'h0000_4760, RESP_OKAY}, '{ADDR_INT_MASK, 32'h0, RESP_OKAY},
      '{ADDR_CTRL, 32'h0, RESP_OKAY}, '{8'h14, 32'h0, RESP_SLVERR}};
   logic [1:0]  straps [3] = '{STRAP_HIGH, 2'h0, STRAP_LOW};
   int          n_fail, num_checks, cyc;
   logic [31:0] d, s_wdata, s_rdata;
   logic [1:0]  r, s_bresp, s_rresp, addr_strap, kind;
   logic [7:0]  s_awaddr, s_araddr;
   logic [3:0]  s_wstrb;
   logic [6:0]  mgmt_addr;
   logic        clk_sys, rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, en_n, flip;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, vbus_sense_pin;
   logic        cc1_rp_det, cc2_rp_det, cc1_rd_det, cc2_rd_det, change_alert_out;
   logic        change_alert_oe, mgmt_mode, cc_rp_en, cc_rd_en, orientation_out;
   logic        active_mode, irq;
   // pulled-up alert wire reads high unless driven
   wire logic   change_alert_in = change_alert_oe ? change_alert_out : 1'b1;

   tpcr_ctrl #(.TOGGLE_T(20), .DEBOUNCE_T(3)) dut_u (.*);
   tpcr_partner partner_u (.*);
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checks=%0d errors=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // hang guard, far above the cycles the flow needs
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end

   task automatic rst(input logic [1:0] s);
      @(posedge clk_sys);
      rstn <= 1'b0;
      addr_strap <= s;
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
   endtask

   // leading edge parts a release from the next request
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      s_awaddr <= a;
      s_wdata <= v;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (!s_bvalid);
      chk(s_bresp, RESP_OKAY);
      s_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
      @(posedge clk_sys);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_arready) s_arvalid <= 1'b0;
      end while (!s_rvalid);
      v = s_rdata;
      e = s_rresp;
      s_rready <= 1'b0;
   endtask

   task automatic wait_act(input logic v);
      for (int i = 0; i < 2000 && active_mode !== v; i++)
         @(posedge clk_sys);
      @(posedge clk_sys) chk(active_mode, v);
   endtask

   initial begin
      {rstn, en_n, flip, kind, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      {s_awaddr, s_araddr, s_wdata, addr_strap} = '0;
      s_wstrb = 4'hF;
      foreach (straps[i]) begin
         rst(straps[i]);
         chk(mgmt_mode, straps[i] != 2'h0);
         chk(mgmt_addr, straps[i] == STRAP_HIGH ? MGMT_ADDR_HIGH : MGMT_ADDR_LOW);
      end
      chk({cc_rd_en, cc_rp_en, active_mode}, 3'b100);
      wr(ADDR_ID, 32'h0);
      foreach (rows[i]) begin
         rd(rows[i].a, d, r);
         chk(d, rows[i].d);
         chk(r, rows[i].r);
      end
      // no partner: dual role toggle reaches the source side
      for (int i = 0; i < 3000 && cc_rp_en !== 1'b1; i++)
         @(posedge clk_sys);
      chk(cc_rp_en, 1'b1);
      // upstream role, source partner on the second line
      wr(ADDR_INT_MASK, 32'h7);
      wr(ADDR_CTRL, {30'h0, ROLE_UFP});
      kind <= 2'h1;
      flip <= 1'b1;
      wait_act(1'b1);
      chk({cc_rd_en, orientation_out}, 2'b11);
      rd(ADDR_INT_STAT, d, r);
      chk(d, 32'h5);
      chk({irq, change_alert_oe, change_alert_out}, 3'b110);
      wr(ADDR_INT_STAT, 32'h7);
      kind <= 2'h0;
      wait_act(1'b0);
      rd(ADDR_INT_STAT, d, r);
      chk(d, 32'h2);
      // downstream role with swapped wiring, then soft reset and detach
      wr(ADDR_CTRL, 32'h0A);
      kind <= 2'h2;
      wait_act(1'b1);
      chk({cc_rp_en, orientation_out}, 2'b10);
      wr(ADDR_INT_STAT, 32'h7);
      wr(ADDR_CTRL, 32'h0E);
      repeat (2) @(posedge clk_sys);
      chk(active_mode, 1'b0);
      rd(ADDR_INT_STAT, d, r);
      chk(d[2], 1'b1);
      wait_act(1'b1);
      kind <= 2'h0;
      wait_act(1'b0);
      // enable falling edge counts as a role exit
      en_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      wr(ADDR_INT_STAT, 32'h7);
      en_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rd(ADDR_INT_STAT, d, r);
      chk(d[2], 1'b1);
      wr(ADDR_INT_MASK, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk({irq, change_alert_oe}, 2'b00);
      test_done();
   end
endmodule // tb_top
